// ---- hw/adc_link_pkg.sv ----
// Purpose: shared constants and types for the converter readout link
// Assumes: one 125 MHz system clock on both ends
// Notes:   times are given in ns and turned into cycle counts here
package adc_link_pkg;
    localparam int unsigned CLK_MHZ       = 125;       // system clock rate
    localparam int unsigned RES_BITS      = 16;        // result width
    localparam int unsigned CONV_TIME_NS  = 500;       // longest conversion
    // least time, so round up to whole cycles
    localparam int unsigned CONV_CYC      =
        (CONV_TIME_NS * CLK_MHZ + 999) / 1000;
    localparam int unsigned SCLK_PER_NS   = 80;        // serial clock period
    // half period, longest time, so round down
    localparam int unsigned HALF_CYC      = (SCLK_PER_NS * CLK_MHZ) / 2000;
    localparam int unsigned HOST_WAIT_CYC = CONV_CYC + 16; // margin for sync
    localparam logic [4:0]  BUSY_FALLS    = 5'h11;     // hi-z at 17th fall
    localparam logic [4:0]  PLAIN_FALLS   = 5'h10;     // hi-z at 16th fall
    localparam logic [15:0] RESULT_RST    = 16'h0000;  // result after reset
    localparam int unsigned FIFO_DEPTH    = 16;        // readout buffer depth

    // readout mode latched at the convert strobe rising edge
    typedef enum logic [2:0] {
        MODE_IDLE       = 3'b000,
        MODE_CS_PLAIN   = 3'b001,
        MODE_CS_BUSY    = 3'b010,
        MODE_CHAIN      = 3'b011,
        MODE_CHAIN_BUSY = 3'b100
    } mode_t;
endpackage

// ---- hw/adc_link_if.sv ----
// Purpose: pin bundle between the converter end and the host end
// Assumes: serial data output line has a pull-up
// Notes:   line level resolved here from the output enable
`timescale 1ns/1ps
interface adc_link_if;
    logic convert_strobe;      // sample and frame strobe, host driven
    logic serial_data_input;   // select / chain input, host driven
    logic sclk;                // serial clock, host driven
    logic serial_data_output;  // device output value
    logic sdo_oe;              // device output enable, high drives
    logic sdo_line;            // resolved line level with pull-up

    assign sdo_line = sdo_oe ? serial_data_output : 1'b1;

    modport device (
        input  convert_strobe,
        input  serial_data_input,
        input  sclk,
        output serial_data_output,
        output sdo_oe
    );
    modport host (
        output convert_strobe,
        output serial_data_input,
        output sclk,
        input  sdo_line
    );
endinterface

// ---- hw/adc_readout_dev.sv ----
// Purpose: converter end of the serial result readout
// Assumes: link pins arrive asynchronously and are synchronised here
// Notes:   conversion is timed by an internal cycle counter
//
// Contract
// - busy select mode only when fast rate off
// - select input high at strobe: convert, hi-z
// - host holds strobe high through select readback
// - select and strobe low: drive output low
// - host holds select low across conversion time
// - busy select mode: drive output at completion
// - after conversion shift MSB first on falls
// - busy select: hi-z at 17th fall or rise
// - bit stands across both serial clock edges
// - select low, clock low: chain, no busy
// - host holds strobe high in chain modes
// - chain plain: MSB on output at completion
// - chain: select input feeds shift register
// - host clocks 16N or 16N plus one
// - select low, clock high: chain with busy
// - chain busy: drive high when all done
// - conversion completes despite strobe changes
`timescale 1ns/1ps
module adc_readout_dev (
    // clock and reset
    input  wire logic                         clk_i,
    input  wire logic                         rst_n_i,
    // link pins
    adc_link_if.device                        link,
    // user side
    input  wire logic                         turbo_i,
    input  wire logic [adc_link_pkg::RES_BITS-1:0] sample_i,
    output logic                              busy_o,
    output adc_link_pkg::mode_t               mode_o
);
    import adc_link_pkg::*;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_CONV = 2'b01,
        ST_READ = 2'b10
    } dev_state_t;

    logic [2:0]          cnv_sync_q;  // two sync flops plus edge history
    logic [2:0]          sdi_sync_q;  // same for the select input
    logic [1:0]          sclk_sync_q; // serial clock sync pair
    logic                sclk_p_q;    // previous synced serial clock
    logic                cnv_rise;    // strobe rising edge
    logic                cnv_fall;    // strobe falling edge
    logic                sdi_rise;    // select input rising edge
    logic                sclk_fall;   // serial clock falling edge
    logic                cnv_s;       // synced strobe level
    logic                sdi_s;       // synced select level
    dev_state_t          state_q;     // conversion state
    mode_t               mode_q;      // latched readout mode
    logic [15:0]         conv_cnt_q;  // conversion timer
    logic [15:0]         sample_q;    // value taken at sampling
    logic [RES_BITS-1:0] sr_q;        // result shift register
    logic [4:0]          fall_cnt_q;  // serial falls since completion
    logic                stop_q;      // output released to hi-z
    logic                sdo_d;
    logic                oe_d;
    logic                sdo_q;
    logic                oe_q;

    // only the second flop is read, the first feeds it alone
    assign cnv_s     = cnv_sync_q[1];
    assign sdi_s     = sdi_sync_q[1];
    assign cnv_rise  = cnv_sync_q[1] & ~cnv_sync_q[2];
    assign cnv_fall  = ~cnv_sync_q[1] & cnv_sync_q[2];
    assign sdi_rise  = sdi_sync_q[1] & ~sdi_sync_q[2];
    assign sclk_fall = ~sclk_sync_q[1] & sclk_p_q;

    // pin synchronisers
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            cnv_sync_q  <= 3'b000;
            sdi_sync_q  <= 3'b000;
            sclk_sync_q <= 2'b00;
            sclk_p_q    <= 1'b0;
        end else begin
            cnv_sync_q  <= {cnv_sync_q[1:0], link.convert_strobe};
            sdi_sync_q  <= {sdi_sync_q[1:0], link.serial_data_input};
            sclk_sync_q <= {sclk_sync_q[0], link.sclk};
            sclk_p_q    <= sclk_sync_q[1];
        end
    end

    // conversion sequencing and mode latch
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            state_q    <= ST_IDLE;
            mode_q     <= MODE_IDLE;
            conv_cnt_q <= 16'h0000;
            sample_q   <= RESULT_RST;
        end else begin
            case (state_q)
                ST_IDLE, ST_READ: begin
                    if (cnv_rise) begin
                        state_q    <= ST_CONV;
                        conv_cnt_q <= 16'(CONV_CYC);
                        sample_q   <= sample_i;
                        if (sdi_s) begin
                            // busy variant needs normal rate
                            mode_q <= turbo_i ? MODE_CS_PLAIN
                                              : MODE_CS_BUSY;
                        end else if (sclk_sync_q[1]) begin
                            mode_q <= MODE_CHAIN_BUSY;
                        end else begin
                            mode_q <= MODE_CHAIN;
                        end
                    end else if (state_q == ST_READ && cnv_fall) begin
                        // strobe low ends the readback frame
                        state_q <= ST_IDLE;
                        mode_q  <= MODE_IDLE;
                    end
                end
                ST_CONV: begin
                    // strobe is ignored until the timer expires
                    if (conv_cnt_q == 16'h0001) begin
                        state_q <= ST_READ;
                    end
                    conv_cnt_q <= conv_cnt_q - 16'h0001;
                end
                default: begin
                    state_q <= ST_IDLE;
                    mode_q  <= MODE_IDLE;
                end
            endcase
        end
    end

    // result shift register and fall counter
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            sr_q       <= RESULT_RST;
            fall_cnt_q <= 5'h00;
            stop_q     <= 1'b0;
        end else if (state_q == ST_CONV) begin
            sr_q       <= sample_q;   // loaded ready for completion
            fall_cnt_q <= 5'h00;
            stop_q     <= 1'b0;
        end else if (state_q == ST_READ) begin
            if (sclk_fall) begin
                if (fall_cnt_q != 5'h1f) begin
                    fall_cnt_q <= fall_cnt_q + 5'h01;
                end
                // busy modes: first fall only presents the MSB, so a
                // chain needs one clock on top of 16 per device
                if (fall_cnt_q != 5'h00 || mode_q == MODE_CS_PLAIN ||
                    mode_q == MODE_CHAIN) begin
                    sr_q <= {sr_q[RES_BITS-2:0], sdi_s};
                end
            end
            if (mode_q == MODE_CS_BUSY &&
                ((sclk_fall && fall_cnt_q == BUSY_FALLS - 5'h01) ||
                 sdi_rise)) begin
                stop_q <= 1'b1;
            end
            if (mode_q == MODE_CS_PLAIN && sclk_fall &&
                fall_cnt_q == PLAIN_FALLS - 5'h01) begin
                stop_q <= 1'b1;
            end
        end
    end

    // output value and enable; bit changes only on falls
    always_comb begin
        sdo_d = 1'b0;
        oe_d  = 1'b0;
        case (mode_q)
            MODE_CS_BUSY: begin
                if (state_q == ST_READ && !stop_q) begin
                    oe_d  = 1'b1;
                    sdo_d = (fall_cnt_q == 5'h00) ? 1'b0
                                                  : sr_q[RES_BITS-1];
                end
            end
            MODE_CS_PLAIN: begin
                oe_d  = (state_q == ST_READ) && !sdi_s && !stop_q;
                sdo_d = sr_q[RES_BITS-1];
            end
            MODE_CHAIN: begin
                oe_d  = 1'b1;
                sdo_d = (state_q == ST_READ) && sr_q[RES_BITS-1];
            end
            MODE_CHAIN_BUSY: begin
                oe_d = 1'b1;
                if (state_q == ST_READ) begin
                    // relay upstream done level after own one
                    sdo_d = (fall_cnt_q == 5'h00) ? sdi_s
                                                  : sr_q[RES_BITS-1];
                end
            end
            default: begin
                // keep a chain line low across the mode latch cycle, a
                // one cycle release would read as a false done level
                oe_d  = cnv_rise && !sdi_s;
                sdo_d = 1'b0;
            end
        endcase
        if (!cnv_s && !sdi_s) begin
            oe_d  = 1'b1;
            sdo_d = 1'b0;
        end
        if (state_q == ST_CONV && mode_q == MODE_CS_BUSY) begin
            oe_d = 1'b0;          // hi-z kept until completion
        end
    end

    // registered pin drive and status
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            sdo_q  <= 1'b0;
            oe_q   <= 1'b0;
            busy_o <= 1'b0;
            mode_o <= MODE_IDLE;
        end else begin
            sdo_q  <= sdo_d;
            oe_q   <= oe_d;
            busy_o <= (state_q == ST_CONV);
            mode_o <= mode_q;
        end
    end

    assign link.serial_data_output = sdo_q;
    assign link.sdo_oe             = oe_q;
endmodule

// ---- hw/adc_readout_host.sv ----
// Purpose: host end, drives strobe, select and serial clock, gathers words
// Assumes: pull-up on the output line, chain far end select tied high
// Notes:   words land in a FIFO; a full FIFO holds the serial clock
`timescale 1ns/1ps
module word_fifo #(
    parameter int unsigned WIDTH = 16,
    parameter int unsigned DEPTH = 16
) (
    // clock and reset
    input  wire logic             clk_i,
    input  wire logic             rst_n_i,
    // fill side
    input  wire logic             in_valid_i,
    output logic                  in_ready_o,
    input  wire logic [WIDTH-1:0] in_data_i,
    // drain side
    output logic                  out_valid_o,
    input  wire logic             out_ready_i,
    output logic [WIDTH-1:0]      out_data_o
);
    localparam int unsigned AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem_q [DEPTH];  // storage
    logic [AW-1:0]    wr_q;           // write pointer
    logic [AW-1:0]    rd_q;           // read pointer
    logic [AW:0]      cnt_q;          // fill level
    logic             push;
    logic             pop;

    assign in_ready_o  = (cnt_q != (AW+1)'(DEPTH));
    assign out_valid_o = (cnt_q != '0);
    assign out_data_o  = mem_q[rd_q];
    assign push        = in_valid_i && in_ready_o;
    assign pop         = out_valid_o && out_ready_i;

    // storage write; no reset needed on data
    always_ff @(posedge clk_i) begin
        if (push) begin
            mem_q[wr_q] <= in_data_i;
        end
    end

    // pointers and level
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            wr_q  <= '0;
            rd_q  <= '0;
            cnt_q <= '0;
        end else begin
            if (push) begin
                wr_q <= wr_q + AW'(1);
            end
            if (pop) begin
                rd_q <= rd_q + AW'(1);
            end
            cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
        end
    end
endmodule

module adc_readout_host (
    // clock and reset
    input  wire logic                  clk_i,
    input  wire logic                  rst_n_i,
    // link pins
    adc_link_if.host                   link,
    // command
    input  wire logic                  start_i,
    input  wire adc_link_pkg::mode_t   mode_i,
    input  wire logic [3:0]            dev_count_i,
    output logic                       idle_o,
    // result words
    output logic                       word_valid_o,
    input  wire logic                  word_ready_i,
    output logic [15:0]                word_o
);
    import adc_link_pkg::*;

    typedef enum logic [2:0] {
        HS_IDLE  = 3'b000,
        HS_SETUP = 3'b001,
        HS_CONV  = 3'b010,
        HS_SHIFT = 3'b011,
        HS_END   = 3'b100
    } host_state_t;

    host_state_t state_q;
    mode_t       mode_q;      // mode of the running frame
    logic [3:0]  div_q;       // serial clock divider
    logic        tick;        // half period enable pulse
    logic [15:0] wait_q;      // conversion wait timer
    logic [8:0]  falls_q;     // falls issued
    logic [8:0]  total_q;     // falls needed for the frame
    logic [3:0]  bit_q;       // bit index in current word
    logic [15:0] word_q;      // word being assembled
    logic [1:0]  line_sync_q; // output line sync pair
    logic        busy_mode;
    logic        fifo_ready;
    logic        push_q;
    logic        cnv_q;
    logic        sdi_q;
    logic        sclk_q;

    assign tick      = (div_q == 4'(HALF_CYC - 1));
    assign busy_mode = (mode_q == MODE_CS_BUSY) ||
                       (mode_q == MODE_CHAIN_BUSY);

    // divider for the serial clock half period
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            div_q <= 4'h0;
        end else begin
            div_q <= tick ? 4'h0 : div_q + 4'h1;
        end
    end

    // line synchroniser
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            line_sync_q <= 2'b11;
        end else begin
            line_sync_q <= {line_sync_q[0], link.sdo_line};
        end
    end

    // frame sequencer
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            state_q <= HS_IDLE;
            mode_q  <= MODE_IDLE;
            cnv_q   <= 1'b0;
            sdi_q   <= 1'b1;
            sclk_q  <= 1'b0;
            wait_q  <= 16'h0000;
            falls_q <= 9'h000;
            total_q <= 9'h000;
            bit_q   <= 4'h0;
            word_q  <= 16'h0000;
            push_q  <= 1'b0;
            idle_o  <= 1'b1;
        end else begin
            push_q <= 1'b0;
            case (state_q)
                HS_IDLE: begin
                    idle_o <= 1'b1;
                    if (start_i && mode_i != MODE_IDLE) begin
                        state_q <= HS_SETUP;
                        idle_o  <= 1'b0;
                        mode_q  <= mode_i;
                        sdi_q   <= (mode_i == MODE_CS_PLAIN) ||
                                   (mode_i == MODE_CS_BUSY);
                        sclk_q  <= (mode_i == MODE_CHAIN_BUSY);
                        falls_q <= 9'h000;
                        bit_q   <= 4'h0;
                        total_q <= {1'b0, dev_count_i, 4'h0} +
                            ((mode_i == MODE_CHAIN_BUSY ||
                              mode_i == MODE_CS_BUSY) ? 9'h001 : 9'h000);
                    end
                end
                HS_SETUP: begin
                    if (tick) begin
                        cnv_q   <= 1'b1;  // held high to frame end
                        state_q <= HS_CONV;
                        wait_q  <= 16'(HOST_WAIT_CYC);
                    end
                end
                HS_CONV: begin
                    if (mode_q == MODE_CS_BUSY) begin
                        sdi_q <= 1'b0;    // low across conversion
                    end
                    if (mode_q == MODE_CHAIN_BUSY) begin
                        sdi_q <= 1'b1;    // far end done level
                    end
                    if (mode_q == MODE_CS_PLAIN) begin
                        sdi_q <= (wait_q > 16'h0001);
                    end
                    if (wait_q != 16'h0000) begin
                        wait_q <= wait_q - 16'h0001;
                    end
                    if ((mode_q == MODE_CS_BUSY && !line_sync_q[1]) ||
                        (mode_q == MODE_CHAIN_BUSY && line_sync_q[1] &&
                         wait_q < 16'(HOST_WAIT_CYC - 4)) ||
                        (!busy_mode && wait_q == 16'h0000)) begin
                        state_q <= HS_SHIFT;
                    end
                end
                HS_SHIFT: begin
                    if (tick) begin
                        if (!sclk_q) begin
                            sclk_q <= 1'b1;
                        end else if (falls_q == total_q) begin
                            state_q <= HS_END;
                        end else if (!(bit_q == 4'hf && !fifo_ready)) begin
                            // sample just before the fall issues
                            if (!(busy_mode && falls_q == 9'h000)) begin
                                word_q <= {word_q[14:0], line_sync_q[1]};
                                bit_q  <= bit_q + 4'h1;
                                push_q <= (bit_q == 4'hf);
                            end
                            sclk_q  <= 1'b0;
                            falls_q <= falls_q + 9'h001;
                        end
                    end
                end
                HS_END: begin
                    cnv_q   <= 1'b0;
                    sdi_q   <= 1'b1;
                    sclk_q  <= 1'b0;
                    state_q <= HS_IDLE;
                end
                default: begin
                    state_q <= HS_IDLE;
                end
            endcase
        end
    end

    word_fifo #(
        .WIDTH (16),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .clk_i       (clk_i),
        .rst_n_i     (rst_n_i),
        .in_valid_i  (push_q),
        .in_ready_o  (fifo_ready),
        .in_data_i   (word_q),
        .out_valid_o (word_valid_o),
        .out_ready_i (word_ready_i),
        .out_data_o  (word_o)
    );

    assign link.convert_strobe    = cnv_q;
    assign link.serial_data_input = sdi_q;
    assign link.sclk              = sclk_q;
endmodule

// ---- verification/adc_link_assertions.sv ----
// Purpose: pin level checks between converter end and host end
// Assumes: one clock domain, pins sampled on clk_i, one converter
// Notes:   frame kind is read off the pins at the strobe rise
`timescale 1ns/1ps
module adc_link_assertions (
    // clock and reset
    input  wire logic clk_i,
    input  wire logic rst_n_i,
    // link pins
    input  wire logic convert_strobe,
    input  wire logic serial_data_input,
    input  wire logic sclk,
    input  wire logic serial_data_output,
    input  wire logic sdo_oe,
    input  wire logic sdo_line
);
    logic       cs_q;    // frame started in select mode
    logic       cnv_p_q; // strobe one cycle back
    logic       sclk_q;  // serial clock one cycle back
    logic [5:0] falls_q; // serial clock falls seen in this frame
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);
    // frame kind and fall count; count clears while the strobe is low
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            cs_q    <= 1'b0;
            cnv_p_q <= 1'b0;
            sclk_q  <= 1'b0;
            falls_q <= 6'h00;
        end else begin
            sclk_q  <= sclk;
            cnv_p_q <= convert_strobe;
            if (convert_strobe && !cnv_p_q)
                cs_q <= serial_data_input;
            if (!convert_strobe)
                falls_q <= 6'h00;
            else if (sclk_q && !sclk)
                falls_q <= falls_q + 6'h01;
        end
    end
    sequence s_sel;
        $rose(convert_strobe) && serial_data_input;
    endsequence
    sequence s_chain_busy;
        $rose(convert_strobe) && !serial_data_input && sclk;
    endsequence
    a_low_drive: assert property (
        (!convert_strobe && !serial_data_input)[*3]
        |=> sdo_oe && !serial_data_output) else $error("line not low");
    a_select_hiz: assert property (
        s_sel |-> ##6 !sdo_oe) else $error("no hi-z at select");
    a_busy_done: assert property (
        s_sel |-> ##[60:90] sdo_oe) else $error("no drive at done");
    a_bit_stands: assert property (
        $rose(sclk) && sdo_oe |=> $stable(serial_data_output)[*4])
        else $error("bit moved after rise");
    a_sel_release: assert property (
        cs_q && $rose(serial_data_input) |-> ##[1:6] !sdo_oe)
        else $error("no release at select rise");
    a_chain_ripple: assert property (
        s_chain_busy |-> ##6 (!sdo_line)[*8] ##[40:80] sdo_line)
        else $error("busy level wrong");
    a_chain_drive: assert property (
        $rose(convert_strobe) && !serial_data_input && !sclk
        |-> ##6 sdo_oe[*8]) else $error("chain output released");
    a_strobe_held: assert property (
        $fell(convert_strobe) |-> $past(convert_strobe, 64))
        else $error("strobe dropped early");
    a_clock_count: assert property (
        $fell(convert_strobe) |-> falls_q == 6'h10 || falls_q == 6'h11)
        else $error("wrong clock count");
endmodule

// ---- verification/adc_serial_readout_busy_chain_bench.sv ----
// Purpose: drives both link ends through every readout mode
// Assumes: one converter on the link, chain length one
// Notes:   inputs change on the falling clock edge
`timescale 1ns/1ps
module adc_serial_readout_busy_chain_bench;
    import adc_link_pkg::*;
    logic        clk_i = 0, rst_n_i = 0, start_i = 0;
    logic        word_ready_i = 0, turbo_i = 0;
    logic [3:0]  dev_count_i = 4'h1;       // single converter
    logic [15:0] sample_i = 16'h0000;      // value to convert
    mode_t       mode_i = MODE_CS_BUSY;    // host frame kind
    wire         idle_o, word_valid_o, busy_o;
    wire  [15:0] word_o;
    mode_t       mode_o;                   // mode the converter took
    int          mismatches = 0, checks_done = 0;
    adc_link_if link();
    adc_readout_dev adc_readout_dev_i (.clk_i(clk_i), .rst_n_i(rst_n_i),
        .link(link), .turbo_i(turbo_i), .sample_i(sample_i),
        .busy_o(busy_o), .mode_o(mode_o));
    adc_readout_host adc_readout_host_i (.clk_i(clk_i),
        .rst_n_i(rst_n_i), .link(link), .start_i(start_i),
        .mode_i(mode_i), .dev_count_i(dev_count_i), .idle_o(idle_o),
        .word_valid_o(word_valid_o), .word_ready_i(word_ready_i),
        .word_o(word_o));
    adc_link_assertions adc_link_assertions_i (.clk_i(clk_i),
        .rst_n_i(rst_n_i), .convert_strobe(link.convert_strobe),
        .serial_data_input(link.serial_data_input), .sclk(link.sclk),
        .serial_data_output(link.serial_data_output),
        .sdo_oe(link.sdo_oe), .sdo_line(link.sdo_line));
    // free running system clock
    initial begin
        forever #4 clk_i = ~clk_i;
    end
    task automatic results;
        $display("checks %0d mismatches %0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    task automatic cmp_word(input logic [15:0] got, input logic [15:0] exp);
        checks_done++;
        if (got !== exp) begin
            mismatches++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic cmp_mode(input mode_t got, input mode_t exp);
        checks_done++;
        if (got !== exp) begin
            mismatches++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // bounded wait: 0 idle, 1 converting, 2 word waiting
    task automatic wait_on(input int k);
        for (int n = 0; n < 4000; n++) begin
            @(negedge clk_i);
            if ((k == 0 && idle_o === 1'b1) || (k == 1 && busy_o === 1'b1)
                || (k == 2 && word_valid_o === 1'b1))
                return;
        end
        mismatches++;
        $display("BAD t=%0t got=%h exp=%h", $time, 0, k);
        results();
    endtask
    // sample stays put until the next frame, past the strobe rise
    task automatic start_frame(input mode_t m, input logic [15:0] s,
                               input mode_t dev_exp);
        wait_on(0);
        sample_i = s;
        mode_i   = m;
        start_i  = 1'b1;
        @(negedge clk_i);
        start_i = 1'b0;
        wait_on(1);
        cmp_mode(mode_o, dev_exp);
    endtask
    task automatic get_word(input logic [15:0] exp);
        wait_on(2);
        cmp_word(word_o, exp);
        word_ready_i = 1'b1;
        @(negedge clk_i);
        word_ready_i = 1'b0;
    endtask
    task automatic t_cs_busy;
        start_frame(MODE_CS_BUSY, 16'hA5C3, MODE_CS_BUSY);
        get_word(16'hA5C3);
        $display("test cs_busy done");
    endtask
    // fast rate forbids the busy select mode
    task automatic t_cs_turbo;
        turbo_i = 1'b1;
        start_frame(MODE_CS_PLAIN, 16'h8001, MODE_CS_PLAIN);
        get_word(16'h8001);
        turbo_i = 1'b0;
        $display("test cs_turbo done");
    endtask
    task automatic t_chain;
        start_frame(MODE_CHAIN, 16'h7FFE, MODE_CHAIN);
        get_word(16'h7FFE);
        $display("test chain done");
    endtask
    task automatic t_chain_busy;
        start_frame(MODE_CHAIN_BUSY, 16'h0001, MODE_CHAIN_BUSY);
        get_word(16'h0001);
        $display("test chain_busy done");
    endtask
    // one frame more than the buffer holds stalls the host
    task automatic t_fifo_fill;
        for (int i = 0; i <= 16; i++)
            start_frame(MODE_CS_BUSY, 16'h1000 + 16'(i), MODE_CS_BUSY);
        repeat (400) @(negedge clk_i);
        cmp_word({15'h0000, idle_o}, 16'h0000);
        for (int i = 0; i <= 16; i++)
            get_word(16'h1000 + 16'(i));
        cmp_word({15'h0000, word_valid_o}, 16'h0000);
        $display("test fifo_fill done");
    endtask
    initial begin
        repeat (20) @(negedge clk_i);
        rst_n_i = 1'b1;
        t_cs_busy();
        t_cs_turbo();
        t_chain();
        t_chain_busy();
        t_fifo_fill();
        results();
    end
endmodule
